// ===== testbench/pstr_host.sv
// Purpose: host model issuing byte and word transactions
// Assumes: one request per call, launched after a rising edge
// Notes:   idle code and data lines show the inverted last value
`timescale 1ns/1ps
module pstr_host (
    // clock
    input wire logic        clk,
    // request
    output logic            cmd_valid, cmd_write, clear_faults,
    output logic [7:0]      cmd_code, cmd_wdata,
    // answer
    input wire logic        rsp_valid, rsp_hit,
    input wire logic [15:0] rsp_data
);
    // idle at time zero
    initial begin
        {cmd_valid, cmd_write, clear_faults, cmd_code, cmd_wdata} = 19'h00000;
    end
    // one transaction, answer taken one cycle after the request edge
    task automatic xfer(input logic w, input logic [7:0] c, input logic [7:0] d,
                        output logic hit, output logic [15:0] q);
        @(posedge clk);
        {cmd_valid, cmd_write, cmd_code, cmd_wdata} <= {1'b1, w, c, d};
        @(posedge clk);
        {cmd_valid, cmd_write, cmd_code, cmd_wdata} <= {1'b0, ~w, ~c, ~d};
        #1;
        hit = rsp_hit & rsp_valid;
        q = rsp_data;
    endtask
    // clear-faults pulse
    task automatic clr();
        @(posedge clk);
        clear_faults <= 1'b1;
        @(posedge clk);
        clear_faults <= 1'b0;
        #1;
    endtask
endmodule // pstr_host

// ===== testbench/pstr_regs_checker.sv
// Purpose: port checks of the status and telemetry bank
// Assumes: one clock, async active-low reset
// Notes:   bound to the design from the bench
`timescale 1ns/1ps
`include "pstr_consts.svh"
module pstr_regs_checker (
    // clock, reset, enable
    input wire logic        clk, rstn, ce,
    // command side
    input wire logic        cmd_valid, cmd_write, clear_faults, rsp_valid,
    input wire logic [7:0]  cmd_code, alert_order_mask,
    input wire logic [15:0] rsp_data,
    // events
    input wire logic        first_alert_evt, trim_bad_evt, settings_sum_bad_evt, strap_bad_evt,
    input wire logic        vout_reset_evt, back_channel_fault, sync_fault_evt,
    // summaries and notices
    input wire logic        summary_other, summary_vendor, invalid_command_flag, alert_req
);
    // any vendor event this cycle
    logic vf_ev;
    assign vf_ev = trim_bad_evt | settings_sum_bad_evt | strap_bad_evt | vout_reset_evt
                 | back_channel_fault | sync_fault_evt;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);
    a_read_answer: assert property (ce && cmd_valid && !cmd_write |=> rsp_valid)
        else $error("read not answered");
    a_answer_cause: assert property (rsp_valid && $past(ce) |-> $past(cmd_valid && !cmd_write))
        else $error("answer without read");
    a_ro_write: assert property (ce && cmd_valid && cmd_write && (cmd_code == 8'h88 ||
        cmd_code == 8'h8B) |=> invalid_command_flag && alert_req) else $error("no invalid flag");
    a_flag_cause: assert property (invalid_command_flag && $past(ce) |-> $past(cmd_valid && cmd_write))
        else $error("invalid flag without write");
    a_vendor_set: assert property (ce && vf_ev |=> summary_vendor)
        else $error("vendor summary not set");
    a_clear_all: assert property (ce && clear_faults && !vf_ev && !first_alert_evt
        |=> !summary_other && !summary_vendor) else $error("clear faults ignored");
    a_mask_pass: assert property (ce && first_alert_evt && !alert_order_mask[0] |=> alert_req)
        else $error("unmasked alert missing");
    a_vf_zeros: assert property (rsp_valid && $past(ce) && $past(cmd_code) == 8'h80
        |-> rsp_data[15:8] == 8'h00 && rsp_data[5:4] == 2'h0 && !rsp_data[0])
        else $error("vendor unused bits set");
    a_ao_zeros: assert property (rsp_valid && $past(ce) && $past(cmd_code) == 8'h7F
        |-> rsp_data[15:1] == 15'h0000) else $error("alert-order upper bits set");
    a_enable_freeze: assert property (!ce |=> $stable(summary_vendor) && $stable(alert_req)
        && $stable(rsp_valid)) else $error("state moved while enable low");
endmodule // pstr_regs_checker

// ===== testbench/tb_pmbus_status_telemetry_regs.sv
// Purpose: self-checking bench of the status and telemetry bank
// Assumes: host model drives commands, bench drives events and readings
// Notes:   refresh shortened to 16 cycles
`timescale 1ns/1ps
`include "pstr_consts.svh"
module tb_pmbus_status_telemetry_regs;
    logic        clk = 1'b0, rstn = 1'b0, self_check_busy = 1'b0, follower_missing = 1'b0, hit;
    logic        ce = 1'b1;
    logic [6:0]  ev = 7'h00; // trim, sum, strap, vout, back channel, sync, first alert
    logic [7:0]  alert_order_mask = 8'h00, vendor_fault_mask = 8'h00, phase_sel = 8'hFF;
    logic [15:0] power_input_voltage = 16'h0000, output_voltage = 16'h0000, q;
    logic [63:0] phase_input_voltage = 64'h0;
    wire logic   cmd_valid, cmd_write, clear_faults, rsp_valid, rsp_hit, summary_other;
    wire logic   summary_vendor, invalid_command_flag, alert_req;
    wire logic [7:0]  cmd_code, cmd_wdata;
    wire logic [15:0] rsp_data;
    integer      seed = 5, err_count = 0, checked = 0, cyc = 0, i;
    always #4 clk = ~clk;
    pstr_host host (.*);
    pstr_regs #(.NUM_PHASES(4), .REFRESH_CYC(16)) dut (.*, .ce(ce), .trim_bad_evt(ev[0]),
        .settings_sum_bad_evt(ev[1]), .strap_bad_evt(ev[2]), .vout_reset_evt(ev[3]),
        .back_channel_fault(ev[4]), .sync_fault_evt(ev[5]), .first_alert_evt(ev[6]));
    // compare and count
    task automatic chk(input logic [16:0] got, input logic [16:0] exp, input string m);
        checked++;
        if (got !== exp) begin
            err_count++;
            $display("CHECK FAILED at %0t: %s", $time, m);
        end
    endtask
    task automatic rw(input logic w, input logic [7:0] c, input logic [7:0] d);
        host.xfer(w, c, d, hit, q);
    endtask
    // one-cycle event pulse, settled on return
    task automatic pulse(input int k);
        @(posedge clk);
        ev <= 7'h01 << k;
        @(posedge clk);
        ev <= 7'h00;
        #1;
    endtask
    function automatic logic [7:0] vf_bit(input int k);
        return (k < 3) ? 8'h80 : 8'h08 >> (k - 3);
    endfunction
    function automatic logic [15:0] exp_vin();
        return (phase_sel < 8'h04) ? phase_input_voltage[phase_sel * 16 +: 16] : power_input_voltage;
    endfunction
    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    // cut a hang short
    always @(posedge clk) begin
        cyc++;
        if (cyc == 4000) begin
            err_count++;
            wrap_up();
        end
    end
    // main sequence
    initial begin
        repeat (5) @(posedge clk);
        rstn <= 1'b1;
        rw(1'b0, 8'h7F, 8'h00);
        chk({hit, q}, 17'h10000, "alert-order at reset");
        rw(1'b1, 8'h80, 8'hFF);
        rw(1'b0, 8'h80, 8'h00);
        chk({hit, q}, 17'h10000, "vendor unused bits");
        rw(1'b0, 8'h55, 8'h00);
        chk({hit, q}, 17'h00000, "unmapped code");
        $display("done: reset values");
        for (i = 0; i < 6; i++) begin
            pulse(i);
            chk(17'(summary_vendor), 17'h00001, "vendor summary");
            rw(1'b1, 8'h80, 8'h00);
            rw(1'b0, 8'h80, 8'h00);
            chk({hit, q}, {9'h100, vf_bit(i)}, "vendor latch");
            rw(1'b1, 8'h80, vf_bit(i));
            rw(1'b0, 8'h80, 8'h00);
            chk({summary_vendor, q}, 17'h00000, "write-one clear");
        end
        for (i = 0; i < 3; i++) begin
            @(posedge clk);
            {follower_missing, self_check_busy} <= 2'h1 << i;
            rw(1'b0, 8'h80, 8'h00);
            chk({summary_vendor, q}, (i < 2) ? 17'h00040 : 17'h0, "live bit");
        end
        $display("done: vendor status");
        pulse(6);
        chk({15'h0, summary_other, alert_req}, 17'h00003, "first alert");
        rw(1'b1, 8'h7F, 8'hFE);
        rw(1'b0, 8'h7F, 8'h00);
        chk({hit, q}, 17'h10001, "alert-order latch");
        rw(1'b1, 8'h7F, 8'hFF);
        rw(1'b0, 8'h7F, 8'h00);
        chk({summary_other, q}, 17'h00000, "alert-order clear");
        @(posedge clk);
        {alert_order_mask, vendor_fault_mask} <= 16'h01FF;
        pulse(6);
        pulse(5);
        chk(17'(alert_req), 17'h0, "masked alert");
        @(posedge clk);
        alert_order_mask <= 8'h00;
        @(posedge clk);
        #1;
        chk(17'(alert_req), 17'h1, "unmasked alert");
        host.clr();
        chk({14'h0, summary_other, summary_vendor, alert_req}, 17'h0, "clear faults");
        $display("done: alerts");
        @(posedge clk);
        ce <= 1'b0;
        pulse(5);
        chk(17'(summary_vendor), 17'h0, "enable low freezes");
        @(posedge clk);
        ce <= 1'b1;
        $display("done: enable freeze");
        for (i = 0; i < 3; i++) begin
            rw(1'b1, (i == 0) ? 8'h88 : (i == 1) ? 8'h8B : 8'h80, 8'($random(seed)));
            chk({15'h0, invalid_command_flag, alert_req}, (i < 2) ? 17'h3 : 17'h0, "ro write");
        end
        for (i = 0; i < 6; i++) begin
            @(posedge clk);
            phase_sel <= (i < 4) ? 8'(i) : (i == 4) ? 8'hFF : 8'h09;
            power_input_voltage <= 16'($random(seed));
            phase_input_voltage <= {$random(seed), $random(seed)};
            output_voltage <= 16'($random(seed));
            repeat (20) @(posedge clk);
            rw(1'b0, 8'h88, 8'h00);
            chk({hit, q}, {1'b1, exp_vin()}, "input reading");
            rw(1'b0, 8'h8B, 8'h00);
            chk({hit, q}, {1'b1, output_voltage}, "output reading");
        end
        $display("done: telemetry");
        pulse(5);
        @(posedge clk);
        rstn <= 1'b0;
        repeat (2) @(posedge clk);
        rstn <= 1'b1;
        #1;
        chk({15'h0, summary_vendor, alert_req}, 17'h0, "mid-run reset");
        rw(1'b0, 8'h88, 8'h00);
        chk({hit, q}, 17'h10000, "reading before refresh");
        $display("done: mid-run reset");
        wrap_up();
    end
endmodule // tb_pmbus_status_telemetry_regs
bind pstr_regs pstr_regs_checker u_chk (.clk(clk), .rstn(rstn), .ce(ce), .cmd_valid(cmd_valid),
    .cmd_write(cmd_write), .clear_faults(clear_faults), .rsp_valid(rsp_valid),
    .cmd_code(cmd_code), .alert_order_mask(alert_order_mask), .rsp_data(rsp_data),
    .first_alert_evt(first_alert_evt), .trim_bad_evt(trim_bad_evt),
    .settings_sum_bad_evt(settings_sum_bad_evt), .strap_bad_evt(strap_bad_evt),
    .vout_reset_evt(vout_reset_evt), .back_channel_fault(back_channel_fault),
    .sync_fault_evt(sync_fault_evt), .summary_other(summary_other),
    .summary_vendor(summary_vendor), .invalid_command_flag(invalid_command_flag),
    .alert_req(alert_req));

// ===== verilog/pstr_consts.svh
// Purpose: constants for the status and telemetry command bank
// Assumes: 125 MHz clock
// Notes:   codes, bit positions, reset values and timing
`ifndef PSTR_CONSTS_SVH
`define PSTR_CONSTS_SVH

// command codes
`define PSTR_CMD_ALERT_ORDER   8'h7F
`define PSTR_CMD_VENDOR_FAULT  8'h80
`define PSTR_CMD_INPUT_V       8'h88
`define PSTR_CMD_OUTPUT_V      8'h8B

// alert-order status field
`define PSTR_AO_FIRST_BIT      0
`define PSTR_AO_RESET          8'h00
`define PSTR_AO_LATCH_MASK     8'h01

// vendor fault status fields
`define PSTR_VF_POWERON_BIT    7
`define PSTR_VF_SELF_BIT       6
`define PSTR_VF_VOUT_RST_BIT   3
`define PSTR_VF_BACK_CH_BIT    2
`define PSTR_VF_SYNC_BIT       1
`define PSTR_VF_LATCH_MASK     8'h8E
`define PSTR_VF_RESET          8'h00

// phase selection meaning all phases
`define PSTR_PHASE_ALL         8'hFF

// input reading layout
`define PSTR_EXP_MSB           15
`define PSTR_EXP_LSB           11
`define PSTR_MAN_MSB           10

// refresh period of the telemetry words
`define PSTR_REFRESH_NS        1000000
`define PSTR_CLK_NS            8
`define PSTR_REFRESH_CYC       (`PSTR_REFRESH_NS / `PSTR_CLK_NS)

`endif

// ===== verilog/pstr_pkg.sv
// Purpose: types for the status and telemetry command bank
// Assumes: nothing
// Notes:   one-hot command selection
package pstr_pkg;
    typedef logic [7:0]  pstr_byte_t;
    typedef logic [15:0] pstr_word_t;
    typedef enum logic [4:0] {
        PSTR_SEL_NONE   = 5'b00001,
        PSTR_SEL_AO     = 5'b00010,
        PSTR_SEL_VF     = 5'b00100,
        PSTR_SEL_VIN    = 5'b01000,
        PSTR_SEL_VOUT   = 5'b10000
    } pstr_sel_t;
endpackage

// ===== verilog/pstr_regs.sv
// Purpose: alert-order and vendor fault status bytes, voltage telemetry words
// Assumes: a command decoder in front hands over one byte or word transaction per pulse
// Notes:   status byte, cml byte and the alert pin itself live outside this block
//
// What this block does
// - alert-order status at code 7Fh, read byte, write byte clears
// - bit 0 latches when this device alerted first; bits 7:1 read zero
// - summary output is the OR of each command's latched flags
// - clearing flags individually also drops the matching summary output
// - vendor fault status at 80h; latched bits clear on clear-faults or write-one
// - bit 7 latches on bad trim check, bad settings checksum or bad strap
// - bit 6 is live: self-check running or a follower silent
// - bits 3, 2, 1 latch output reset, back-channel and sync faults
// - bits 5:4 and 0 read zero and ignore writes
// - writing one clears a set bit; writing zero leaves it
// - each alert-capable bit has a mask bit that blocks the alert
// - input reading at 88h, read word only, refreshed every 1 ms
// - input word: exponent in 15:11, mantissa in 10:0, both signed
// - writing a read-only code raises invalid command and alert
// - phase all-ones: input reading is the stack leader's supply
// - phase below NUM_PHASES: input reading is that phase device's supply; any other phase gives the leader's supply
// - output reading at 8Bh, read word only, unsigned, refreshed every 1 ms
`timescale 1ns/1ps
`include "pstr_consts.svh"

module pstr_regs #(
    parameter int NUM_PHASES  = 4,
    parameter int REFRESH_CYC = `PSTR_REFRESH_CYC
) (
    // clock, reset, enable
    input  wire logic                    clk,
    input  wire logic                    rstn,
    input  wire logic                    ce,
    // command transactions
    input  wire logic                    cmd_valid,
    input  wire logic                    cmd_write,
    input  wire logic [7:0]              cmd_code,
    input  wire logic [7:0]              cmd_wdata,
    input  wire logic                    clear_faults,
    // read answer
    output logic                         rsp_valid,
    output logic                         rsp_hit,
    output logic [15:0]                  rsp_data,
    // alert-order event
    input  wire logic                    first_alert_evt,
    // vendor fault events and live levels
    input  wire logic                    trim_bad_evt,
    input  wire logic                    settings_sum_bad_evt,
    input  wire logic                    strap_bad_evt,
    input  wire logic                    self_check_busy,
    input  wire logic                    follower_missing,
    input  wire logic                    vout_reset_evt,
    input  wire logic                    back_channel_fault,
    input  wire logic                    sync_fault_evt,
    // alert masks, one bit per status bit
    input  wire logic [7:0]              alert_order_mask,
    input  wire logic [7:0]              vendor_fault_mask,
    // measurements
    input  wire logic [7:0]              phase_sel,
    input  wire logic [15:0]             power_input_voltage,
    input  wire logic [NUM_PHASES*16-1:0] phase_input_voltage,
    input  wire logic [15:0]             output_voltage,
    // summaries and notices
    output logic                         summary_other,
    output logic                         summary_vendor,
    output logic                         invalid_command_flag,
    output logic                         alert_req
);

    pstr_pkg::pstr_sel_t  sel;
    pstr_pkg::pstr_byte_t ao_r;
    pstr_pkg::pstr_byte_t ao_nxt;
    pstr_pkg::pstr_byte_t vf_r;
    pstr_pkg::pstr_byte_t vf_nxt;
    pstr_pkg::pstr_byte_t ao_view;
    pstr_pkg::pstr_byte_t vf_view;
    pstr_pkg::pstr_byte_t ao_clr;
    pstr_pkg::pstr_byte_t vf_clr;
    pstr_pkg::pstr_byte_t vf_set;
    pstr_pkg::pstr_word_t vin_src;
    pstr_pkg::pstr_word_t vin_r;
    pstr_pkg::pstr_word_t vout_r;
    pstr_pkg::pstr_byte_t ao_set;
    logic                 tick;
    logic                 wr_ro;

    // decode of the command code
    always_comb begin
        case (cmd_code)
            `PSTR_CMD_ALERT_ORDER:  sel = pstr_pkg::PSTR_SEL_AO;
            `PSTR_CMD_VENDOR_FAULT: sel = pstr_pkg::PSTR_SEL_VF;
            `PSTR_CMD_INPUT_V:      sel = pstr_pkg::PSTR_SEL_VIN;
            `PSTR_CMD_OUTPUT_V:     sel = pstr_pkg::PSTR_SEL_VOUT;
            default:                sel = pstr_pkg::PSTR_SEL_NONE;
        endcase
    end

    // write-one clear masks, only supported latched bits take them
    always_comb begin
        ao_clr = 8'h00;
        vf_clr = 8'h00;
        if (clear_faults) begin
            ao_clr = 8'hFF;
            vf_clr = 8'hFF;
        end
        if (cmd_valid && cmd_write) begin
            if (sel == pstr_pkg::PSTR_SEL_AO) begin
                ao_clr = ao_clr | cmd_wdata;
            end
            if (sel == pstr_pkg::PSTR_SEL_VF) begin
                vf_clr = vf_clr | cmd_wdata;
            end
        end
    end

    // vendor fault set terms
    always_comb begin
        vf_set = 8'h00;
        vf_set[`PSTR_VF_POWERON_BIT]  = trim_bad_evt | settings_sum_bad_evt
                                      | strap_bad_evt;
        vf_set[`PSTR_VF_VOUT_RST_BIT] = vout_reset_evt;
        vf_set[`PSTR_VF_BACK_CH_BIT]  = back_channel_fault;
        vf_set[`PSTR_VF_SYNC_BIT]     = sync_fault_evt;
    end

    // alert-order set term: only the first-to-alert position exists
    always_comb begin
        ao_set = 8'h00;
        ao_set[`PSTR_AO_FIRST_BIT] = first_alert_evt;
    end

    // alert-order latch byte; a set in the clearing cycle wins
    pstr_flag_byte #(
        .SUPPORTED (`PSTR_AO_LATCH_MASK),
        .RESET_VAL (`PSTR_AO_RESET)
    ) u_ao_flags (
        .clk       (clk),
        .rstn      (rstn),
        .ce        (ce),
        .set_bits  (ao_set),
        .clr_bits  (ao_clr),
        .flags_r   (ao_r),
        .flags_nxt (ao_nxt)
    );

    // vendor fault latch byte; unsupported positions never latch
    pstr_flag_byte #(
        .SUPPORTED (`PSTR_VF_LATCH_MASK),
        .RESET_VAL (`PSTR_VF_RESET)
    ) u_vf_flags (
        .clk       (clk),
        .rstn      (rstn),
        .ce        (ce),
        .set_bits  (vf_set),
        .clr_bits  (vf_clr),
        .flags_r   (vf_r),
        .flags_nxt (vf_nxt)
    );

    // read views; live self-check bit merged in
    always_comb begin
        ao_view = ao_r;
        vf_view = vf_r;
        vf_view[`PSTR_VF_SELF_BIT] = self_check_busy | follower_missing;
    end

    // refresh tick every period
    pstr_tick_gen #(
        .PERIOD (REFRESH_CYC)
    ) u_tick (
        .clk  (clk),
        .rstn (rstn),
        .ce   (ce),
        .tick (tick)
    );

    // phase choice of the input source
    always_comb begin
        vin_src = power_input_voltage;
        for (int i = 0; i < NUM_PHASES; i++) begin
            if (phase_sel != `PSTR_PHASE_ALL && phase_sel == 8'(i)) begin
                vin_src = phase_input_voltage[i*16 +: 16];
            end
        end
    end

    // input word snapshot, whole word taken on the tick
    pstr_snap_word #(
        .WIDTH (16)
    ) u_vin_snap (
        .clk    (clk),
        .rstn   (rstn),
        .ce     (ce),
        .take   (tick),
        .src    ({vin_src[`PSTR_EXP_MSB:`PSTR_EXP_LSB], vin_src[`PSTR_MAN_MSB:0]}),
        .word_r (vin_r)
    );

    // output word snapshot on the same tick
    pstr_snap_word #(
        .WIDTH (16)
    ) u_vout_snap (
        .clk    (clk),
        .rstn   (rstn),
        .ce     (ce),
        .take   (tick),
        .src    (output_voltage),
        .word_r (vout_r)
    );

    // write to a read-only word is refused
    assign wr_ro = cmd_valid && cmd_write
                && (sel == pstr_pkg::PSTR_SEL_VIN
                    || sel == pstr_pkg::PSTR_SEL_VOUT);

    // answer to reads, one cycle after the request
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rsp_valid <= 1'b0;
            rsp_hit   <= 1'b0;
            rsp_data  <= 16'h0000;
        end else if (ce) begin
            rsp_valid <= cmd_valid && !cmd_write;
            rsp_hit   <= cmd_valid && !cmd_write
                      && sel != pstr_pkg::PSTR_SEL_NONE;
            if (cmd_valid && !cmd_write) begin
                case (sel)
                    pstr_pkg::PSTR_SEL_AO:   rsp_data <= {8'h00, ao_view};
                    pstr_pkg::PSTR_SEL_VF:   rsp_data <= {8'h00, vf_view};
                    pstr_pkg::PSTR_SEL_VIN:  rsp_data <= vin_r;
                    pstr_pkg::PSTR_SEL_VOUT: rsp_data <= vout_r;
                    default:                 rsp_data <= 16'h0000;
                endcase
            end
        end
    end

    // summaries follow the latches, so individual clears drop them
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            summary_other  <= 1'b0;
            summary_vendor <= 1'b0;
        end else if (ce) begin
            summary_other  <= |ao_nxt;
            summary_vendor <= |vf_nxt;
        end
    end

    // invalid command notice, one cycle pulse
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            invalid_command_flag <= 1'b0;
        end else if (ce) begin
            invalid_command_flag <= wr_ro;
        end
    end

    // alert request from unmasked latched bits and refused writes
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            alert_req <= 1'b0;
        end else if (ce) begin
            alert_req <= (|(ao_nxt & ~alert_order_mask))
                       | (|(vf_nxt & ~vendor_fault_mask))
                       | wr_ro;
        end
    end

endmodule // pstr_regs

// one byte of latched status flags, set wins over clear
module pstr_flag_byte #(
    parameter logic [7:0] SUPPORTED = 8'hFF,
    parameter logic [7:0] RESET_VAL = 8'h00
) (
    // clock, reset, enable
    input  wire logic       clk,
    input  wire logic       rstn,
    input  wire logic       ce,
    // set and clear terms
    input  wire logic [7:0] set_bits,
    input  wire logic [7:0] clr_bits,
    // latched flags and their next value
    output logic      [7:0] flags_r,
    output logic      [7:0] flags_nxt
);
    // an event in the clearing cycle survives; unsupported positions stay zero
    always_comb begin
        flags_nxt = ((flags_r & ~clr_bits) | set_bits) & SUPPORTED;
    end

    // flag storage, frozen while the enable is low
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            flags_r <= RESET_VAL;
        end else if (ce) begin
            flags_r <= flags_nxt;
        end
    end
endmodule // pstr_flag_byte

// period counter giving a one-cycle tick every PERIOD enabled cycles
module pstr_tick_gen #(
    parameter int PERIOD = `PSTR_REFRESH_CYC
) (
    // clock, reset, enable
    input  wire logic clk,
    input  wire logic rstn,
    input  wire logic ce,
    // one-cycle tick
    output logic      tick
);
    logic [31:0] cnt_r;

    // counts up to the end of the period, then starts over
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            cnt_r <= 32'h00000000;
        end else if (ce) begin
            if (tick) begin
                cnt_r <= 32'h00000000;
            end else begin
                cnt_r <= cnt_r + 32'h00000001;
            end
        end
    end

    // last cycle of the period
    assign tick = (cnt_r >= 32'(PERIOD - 1));
endmodule // pstr_tick_gen

// whole-word capture register: every bit is taken at the same edge
module pstr_snap_word #(
    parameter int WIDTH = 16
) (
    // clock, reset, enable
    input  wire logic             clk,
    input  wire logic             rstn,
    input  wire logic             ce,
    // capture strobe and source
    input  wire logic             take,
    input  wire logic [WIDTH-1:0] src,
    // held snapshot
    output logic      [WIDTH-1:0] word_r
);
    // one register for the word, so a reader never mixes halves of two updates
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            word_r <= '0;
        end else if (ce && take) begin
            word_r <= src;
        end
    end
endmodule // pstr_snap_word
